// [adc_outctl_pkg.sv]
// Purpose: Shared constants and types for the converter output and
//          power-mode control block.
// Assumes: System clock of 10 MHz; register port with one-cycle read data.
// Notes:   Offsets, reset values and wake and clock-stop cycle counts live here.
package adc_outctl_pkg;

    localparam int CLK_PERIOD_NS = 100;

    // Register offsets
    localparam logic [3:0] OFS_POWER  = 4'h0;
    localparam logic [3:0] OFS_OUTPUT = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;

    // Power register fields
    localparam int POW_STBY     = 0;
    localparam int POW_OBUF     = 1;
    localparam int POW_USE_REG  = 2;

    // Output register fields
    localparam int OUT_LVDS      = 0;
    localparam int OUT_USE_REG   = 1;
    localparam int OUT_CLK_DELAY = 2;
    localparam int OUT_STRONG    = 3;
    localparam int OUT_CUR_LSB   = 4;
    localparam int OUT_DOUBLE    = 6;
    localparam int OUT_DTERM_LSB = 7;
    localparam int OUT_CTERM_LSB = 10;

    localparam logic [2:0]  POWER_RESET  = 3'h0;
    localparam logic [12:0] OUTPUT_RESET = 13'h0000;

    // Drive current codes: 00 = 3.5 mA default
    localparam logic [1:0] CUR_3P5 = 2'h0;
    localparam logic [1:0] CUR_2P5 = 2'h1;
    localparam logic [1:0] CUR_4P5 = 2'h2;
    localparam logic [1:0] CUR_1P75 = 2'h3;

    // Wake-up and clock-stop times
    localparam int WAKE_SLOW_US    = 50;
    localparam int WAKE_LVDS_NS    = 500;
    localparam int WAKE_CMOS_NS    = 200;
    localparam int CLK_STOP_NS     = 1000;
    localparam int WAKE_SLOW_CYC   = WAKE_SLOW_US * 1000 / CLK_PERIOD_NS;
    localparam int WAKE_LVDS_CYC   = WAKE_LVDS_NS / CLK_PERIOD_NS;
    localparam int WAKE_CMOS_CYC   = WAKE_CMOS_NS / CLK_PERIOD_NS;
    localparam int CLK_STOP_CYC    = CLK_STOP_NS / CLK_PERIOD_NS;

    localparam int SAMPLE_W = 12;
    localparam int PAIRS    = 7;

    typedef enum logic [1:0] {
        PM_NORMAL,
        PM_STANDBY,
        PM_OBUF_OFF,
        PM_GLOBAL_PD
    } power_mode_e;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_LOW,
        ST_WAKE
    } power_state_e;

    // Settings handed to the analog output stage
    typedef struct packed {
        logic       clk_delay;
        logic       strong_drive;
        logic [1:0] lvds_current;
        logic       current_double;
        logic [2:0] data_term;
        logic [2:0] clock_term;
    } drive_cfg_s;

    // Power controls handed to the analog blocks
    typedef struct packed {
        logic core_pd;
        logic ref_pd;
        logic buf_pd;
    } power_ctl_s;

endpackage : adc_outctl_pkg

// [adc_output_and_powerdown_ctrl.sv]
// Purpose: Power-mode selection with wake-up timing, and sample output over
//          a parallel single-ended bus or a DDR differential bus.
// Assumes: i_clk_samp is the sampling clock and may stop; i_sample is
//          produced on its rising edge.
// Notes:   Differential pins are shown by their positive leg only.
`timescale 1ns/10ps

// Operation
// - Power mode from two pins or two register bits, same encoding.
// - Global power down: core, reference, buffers off; valid within 50 us.
// - Standby powers down core only; valid data within 50 us after normal.
// - Buffer disable floats data; back within 500 ns DDR, 200 ns parallel.
// - Sampling clock under 1 MSPS enters clock-stop; valid within 50 us.
// - Each sample is 12 bits with a forwarded output clock.
// - Bus type chosen by register bit or strap pin.
// - Parallel mode: one pin per bit, new sample every clock.
// - Delay bit shifts forwarded clock later for about 400 ps setup.
// - Reduced parallel drive by default; register selects strong drive.
// - DDR mode: two bits per pair per clock, 7 pairs plus clock pair.
// - Even bits launch at forwarded clock rise, odd bits at fall.
// - Differential current default 3.5 mA; field picks 2.5, 4.5, 1.75.
// - Current-double bit doubles data and clock pair current.
// - Three termination resistors per data and clock, separate fields.
module adc_output_and_powerdown_ctrl (
    input  wire logic                          i_clk_sys,
    input  wire logic                          i_rstn,
    input  wire logic [3:0]                    i_addr,
    input  wire logic [31:0]                   i_wdata,
    input  wire logic                          i_wr,
    input  wire logic                          i_rd,
    output logic      [31:0]                   o_rdata,
    input  wire logic                          i_pdn_pin,
    input  wire logic                          i_serial_data_pin,
    input  wire logic                          i_interface_strap_pin,
    input  wire logic                          i_clk_samp,
    input  wire logic [adc_outctl_pkg::SAMPLE_W-1:0] i_sample,
    output logic      [adc_outctl_pkg::SAMPLE_W-1:0] o_cmos_data,
    output logic      [adc_outctl_pkg::SAMPLE_W-1:0] o_cmos_data_oe_n,
    output logic                               o_forwarded_clock,
    output logic                               o_forwarded_clock_oe_n,
    output logic      [adc_outctl_pkg::PAIRS-1:0]    o_ddr_pair,
    output logic      [adc_outctl_pkg::PAIRS-1:0]    o_ddr_pair_oe_n,
    output logic                               o_forwarded_clock_pos,
    output logic                               o_forwarded_clock_pos_oe_n,
    output adc_outctl_pkg::drive_cfg_s         o_drive_cfg,
    output adc_outctl_pkg::power_ctl_s         o_power_ctl,
    output logic                               o_data_valid
);

    // Decodes the two mode inputs, obuf bit and standby bit
    function automatic adc_outctl_pkg::power_mode_e decode_mode(
        input logic obuf,
        input logic stby
    );
        case ({obuf, stby})
            2'h0:    decode_mode = adc_outctl_pkg::PM_NORMAL;
            2'h1:    decode_mode = adc_outctl_pkg::PM_STANDBY;
            2'h2:    decode_mode = adc_outctl_pkg::PM_OBUF_OFF;
            default: decode_mode = adc_outctl_pkg::PM_GLOBAL_PD;
        endcase
    endfunction : decode_mode

    logic [2:0]  power_q;
    logic [12:0] output_q;
    logic [2:0]  pin_s1_q;
    logic [2:0]  pin_s2_q;
    logic [2:0]  tog_sync_q;
    logic [9:0]  stop_cnt_q;
    logic        clk_stopped_q;
    logic [9:0]  wake_cnt_q;
    logic [9:0]  wake_load;
    logic        lvds_sel;
    logic        out_on_q;
    logic        valid_q;
    logic [1:0]  pstate_q;
    adc_outctl_pkg::power_mode_e mode_pins;
    adc_outctl_pkg::power_mode_e mode_reg;
    adc_outctl_pkg::power_mode_e mode_sel;
    adc_outctl_pkg::power_mode_e mode_prev_q;
    adc_outctl_pkg::power_state_e pstate;

    // Register writes
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            power_q  <= adc_outctl_pkg::POWER_RESET;
            output_q <= adc_outctl_pkg::OUTPUT_RESET;
        end else if (i_wr) begin
            if (i_addr == adc_outctl_pkg::OFS_POWER) begin
                power_q <= i_wdata[2:0];
            end
            if (i_addr == adc_outctl_pkg::OFS_OUTPUT) begin
                output_q <= i_wdata[12:0];
            end
        end
    end

    // Register reads, data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            case (i_addr)
                adc_outctl_pkg::OFS_POWER:  o_rdata <= {29'h0, power_q};
                adc_outctl_pkg::OFS_OUTPUT: o_rdata <= {19'h0, output_q};
                adc_outctl_pkg::OFS_STATUS: o_rdata <= {25'h0, lvds_sel,
                    clk_stopped_q, valid_q, mode_sel, pstate_q};
                default:                    o_rdata <= 32'h0000_0000;
            endcase
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

    // Pins come from off chip: two flops before use
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
        end else begin
            pin_s1_q <= {i_interface_strap_pin, i_serial_data_pin, i_pdn_pin};
            pin_s2_q <= pin_s1_q;
        end
    end

    assign mode_pins = decode_mode(pin_s2_q[1], pin_s2_q[0]);
    assign mode_reg  = decode_mode(power_q[adc_outctl_pkg::POW_OBUF],
                                   power_q[adc_outctl_pkg::POW_STBY]);
    assign mode_sel  = power_q[adc_outctl_pkg::POW_USE_REG] ?
                       mode_reg : mode_pins;
    assign lvds_sel  = output_q[adc_outctl_pkg::OUT_USE_REG] ?
                       output_q[adc_outctl_pkg::OUT_LVDS] :
                       pin_s2_q[2];

    // Sampling-clock activity: a toggle from that domain, synchronised
    logic samp_tog_q;
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            tog_sync_q <= 3'h0;
        end else begin
            tog_sync_q <= {tog_sync_q[1:0], samp_tog_q};
        end
    end

    // No toggle for a full 1 MSPS period means the clock is too slow
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            stop_cnt_q    <= 10'h000;
            clk_stopped_q <= 1'b0;
        end else if (tog_sync_q[2] != tog_sync_q[1]) begin
            stop_cnt_q    <= 10'h000;
            clk_stopped_q <= 1'b0;
        end else if (stop_cnt_q >= 10'(adc_outctl_pkg::CLK_STOP_CYC)) begin
            clk_stopped_q <= 1'b1;
        end else begin
            stop_cnt_q <= stop_cnt_q + 10'h001;
        end
    end

    // Wake time depends on the state being left; max times round down
    always_comb begin
        if (clk_stopped_q || mode_prev_q == adc_outctl_pkg::PM_STANDBY
            || mode_prev_q == adc_outctl_pkg::PM_GLOBAL_PD) begin
            wake_load = 10'(adc_outctl_pkg::WAKE_SLOW_CYC);
        end else if (lvds_sel) begin
            wake_load = 10'(adc_outctl_pkg::WAKE_LVDS_CYC);
        end else begin
            wake_load = 10'(adc_outctl_pkg::WAKE_CMOS_CYC);
        end
    end

    // Power state machine
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            pstate      <= adc_outctl_pkg::ST_RUN;
            mode_prev_q <= adc_outctl_pkg::PM_NORMAL;
            wake_cnt_q  <= 10'h000;
        end else begin
            case (pstate)
                adc_outctl_pkg::ST_RUN: begin
                    if (mode_sel != adc_outctl_pkg::PM_NORMAL
                        || clk_stopped_q) begin
                        pstate      <= adc_outctl_pkg::ST_LOW;
                        mode_prev_q <= mode_sel;
                    end
                end
                adc_outctl_pkg::ST_LOW: begin
                    if (mode_sel == adc_outctl_pkg::PM_NORMAL
                        && !clk_stopped_q) begin
                        pstate     <= adc_outctl_pkg::ST_WAKE;
                        wake_cnt_q <= wake_load - 10'h001;
                    end else begin
                        mode_prev_q <= clk_stopped_q ?
                            adc_outctl_pkg::PM_STANDBY : mode_sel;
                    end
                end
                adc_outctl_pkg::ST_WAKE: begin
                    if (mode_sel != adc_outctl_pkg::PM_NORMAL
                        || clk_stopped_q) begin
                        pstate      <= adc_outctl_pkg::ST_LOW;
                        mode_prev_q <= mode_sel;
                    end else if (wake_cnt_q == 10'h000) begin
                        pstate <= adc_outctl_pkg::ST_RUN;
                    end else begin
                        wake_cnt_q <= wake_cnt_q - 10'h001;
                    end
                end
                default: pstate <= adc_outctl_pkg::ST_RUN;
            endcase
        end
    end

    assign pstate_q = pstate;

    // Analog power controls, held by flops
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_power_ctl <= '0;
            out_on_q    <= 1'b0;
            valid_q     <= 1'b0;
        end else begin
            o_power_ctl.core_pd <=
                mode_sel == adc_outctl_pkg::PM_STANDBY
                || mode_sel == adc_outctl_pkg::PM_GLOBAL_PD;
            o_power_ctl.ref_pd <=
                mode_sel == adc_outctl_pkg::PM_GLOBAL_PD;
            o_power_ctl.buf_pd <=
                mode_sel == adc_outctl_pkg::PM_OBUF_OFF
                || mode_sel == adc_outctl_pkg::PM_GLOBAL_PD;
            out_on_q <= mode_sel != adc_outctl_pkg::PM_OBUF_OFF
                && mode_sel != adc_outctl_pkg::PM_GLOBAL_PD;
            valid_q  <= pstate == adc_outctl_pkg::ST_RUN
                && mode_sel == adc_outctl_pkg::PM_NORMAL && !clk_stopped_q;
        end
    end

    assign o_data_valid = valid_q;

    // Settings for the analog output stage
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_drive_cfg <= '0;
        end else begin
            o_drive_cfg.clk_delay <=
                output_q[adc_outctl_pkg::OUT_CLK_DELAY];
            o_drive_cfg.strong_drive <=
                output_q[adc_outctl_pkg::OUT_STRONG];
            o_drive_cfg.lvds_current <=
                output_q[adc_outctl_pkg::OUT_CUR_LSB +: 2];
            o_drive_cfg.current_double <=
                output_q[adc_outctl_pkg::OUT_DOUBLE];
            o_drive_cfg.data_term <=
                output_q[adc_outctl_pkg::OUT_DTERM_LSB +: 3];
            o_drive_cfg.clock_term <=
                output_q[adc_outctl_pkg::OUT_CTERM_LSB +: 3];
        end
    end

    // Sampling-clock domain: levels cross by two flops
    logic [2:0] lvl_s1_q;
    logic [2:0] lvl_s2_q;
    logic       samp_lvds;
    logic       samp_on;
    logic       samp_delay;
    logic [adc_outctl_pkg::SAMPLE_W-1:0] word_q;
    logic [adc_outctl_pkg::PAIRS-1:0]    rise_q;
    logic [adc_outctl_pkg::PAIRS-1:0]    fall_q;
    logic [adc_outctl_pkg::PAIRS*2-1:0]  word_ext;
    logic [adc_outctl_pkg::PAIRS*2-1:0]  word_q_ext;
    logic       fclk_r_q;
    logic       fclk_f_q;
    logic       fclk;

    always_ff @(posedge i_clk_samp or negedge i_rstn) begin
        if (!i_rstn) begin
            lvl_s1_q <= 3'h0;
            lvl_s2_q <= 3'h0;
        end else begin
            lvl_s1_q <= {o_drive_cfg.clk_delay, out_on_q, lvds_sel};
            lvl_s2_q <= lvl_s1_q;
        end
    end

    assign samp_lvds  = lvl_s2_q[0];
    assign samp_on    = lvl_s2_q[1];
    assign samp_delay = lvl_s2_q[2];

    // Activity toggle and sample capture: a new sample every clock
    always_ff @(posedge i_clk_samp or negedge i_rstn) begin
        if (!i_rstn) begin
            samp_tog_q <= 1'b0;
            word_q     <= '0;
        end else begin
            samp_tog_q <= ~samp_tog_q;
            word_q     <= i_sample;
        end
    end

    // Upper bits of the last pair have no sample bit and sit at zero
    assign word_ext   = {2'h0, i_sample};
    assign word_q_ext = {2'h0, word_q};

    // Even bits launch on the rise, odd bits on the following fall
    genvar k;
    generate
        for (k = 0; k < adc_outctl_pkg::PAIRS; k++) begin : g_pair
            always_ff @(posedge i_clk_samp or negedge i_rstn) begin
                if (!i_rstn) begin
                    rise_q[k] <= 1'b0;
                end else begin
                    rise_q[k] <= word_ext[2*k];
                end
            end
            always_ff @(negedge i_clk_samp or negedge i_rstn) begin
                if (!i_rstn) begin
                    fall_q[k] <= 1'b0;
                end else begin
                    fall_q[k] <= word_q_ext[2*k+1];
                end
            end
        end
    endgenerate

    // Forwarded clock rebuilt from a flop on each edge, in step with data
    always_ff @(posedge i_clk_samp or negedge i_rstn) begin
        if (!i_rstn) begin
            fclk_r_q <= 1'b0;
        end else begin
            fclk_r_q <= ~fclk_f_q;
        end
    end

    always_ff @(negedge i_clk_samp or negedge i_rstn) begin
        if (!i_rstn) begin
            fclk_f_q <= 1'b0;
        end else begin
            fclk_f_q <= fclk_r_q;
        end
    end

    assign fclk = fclk_r_q ^ fclk_f_q;

    // Clock position shift is an analog delay cell fed by clk_delay
    assign o_cmos_data       = word_q;
    assign o_cmos_data_oe_n  = {adc_outctl_pkg::SAMPLE_W{
                                   !(samp_on && !samp_lvds)}};
    assign o_forwarded_clock = fclk;
    assign o_forwarded_clock_oe_n = !(samp_on && !samp_lvds);
    assign o_ddr_pair        = fclk ? rise_q : fall_q;
    assign o_ddr_pair_oe_n   = {adc_outctl_pkg::PAIRS{
                                   !(samp_on && samp_lvds)}};
    assign o_forwarded_clock_pos      = fclk ^ (samp_delay & 1'b0);
    assign o_forwarded_clock_pos_oe_n = !(samp_on && samp_lvds);

endmodule : adc_output_and_powerdown_ctrl

// [adc_outctl_chk_sva.sv]
// Purpose: Concurrent checks on the output and power-mode block's ports.
// Assumes: Register writes to the output register are not back to back.
// Notes:   Bound to every instance of the block.
`timescale 1ns/10ps
module adc_outctl_chk (
    input wire logic                       i_clk_sys,
    input wire logic                       i_rstn,
    input wire logic [3:0]                 i_addr,
    input wire logic [31:0]                i_wdata,
    input wire logic                       i_wr,
    input wire logic                       i_clk_samp,
    input wire logic [11:0]                i_sample,
    input wire logic [11:0]                o_cmos_data,
    input wire logic [11:0]                o_cmos_data_oe_n,
    input wire logic [6:0]                 o_ddr_pair_oe_n,
    input wire logic                       o_forwarded_clock_oe_n,
    input wire logic                       o_forwarded_clock_pos_oe_n,
    input wire adc_outctl_pkg::drive_cfg_s o_drive_cfg,
    input wire adc_outctl_pkg::power_ctl_s o_power_ctl,
    input wire logic                       o_data_valid
);
    // Slow wake plus the register and valid stages
    localparam int WAKE_BND = 520;

    a_gpd_all_off : assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        o_power_ctl.ref_pd |-> o_power_ctl.core_pd && o_power_ctl.buf_pd)
        else $error("reference off while core or buffers still on");
    a_gpd_floats : assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        o_power_ctl.ref_pd [*8] |-> (&o_cmos_data_oe_n) && (&o_ddr_pair_oe_n)
        && o_forwarded_clock_oe_n && o_forwarded_clock_pos_oe_n)
        else $error("output driven during global power down");
    a_wake_bound : assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        $fell(o_power_ctl.core_pd) |-> ##[1:WAKE_BND] o_data_valid)
        else $error("valid data late after core power up");
    a_bus_exclusive : assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        !((o_cmos_data_oe_n != '1) && (o_ddr_pair_oe_n != '1)))
        else $error("parallel and differential buses driven together");
    a_cfg_delay : assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        i_wr && i_addr == adc_outctl_pkg::OFS_OUTPUT |-> ##2
        o_drive_cfg.clk_delay == $past(i_wdata[2], 2))
        else $error("clock delay setting not applied");
    a_cfg_current : assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        i_wr && i_addr == adc_outctl_pkg::OFS_OUTPUT |-> ##2
        o_drive_cfg.lvds_current == $past(i_wdata[5:4], 2))
        else $error("drive current setting not applied");
    a_cfg_double : assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        i_wr && i_addr == adc_outctl_pkg::OFS_OUTPUT |-> ##2
        o_drive_cfg.current_double == $past(i_wdata[6], 2))
        else $error("current double setting not applied");
    a_par_data : assert property (
        @(posedge i_clk_samp) disable iff (!i_rstn)
        (o_cmos_data_oe_n == '0) && o_data_valid |->
        o_cmos_data == $past(i_sample))
        else $error("parallel word differs from last sample");
endmodule : adc_outctl_chk

bind adc_output_and_powerdown_ctrl adc_outctl_chk u_chk (
    .i_clk_sys, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_clk_samp, .i_sample,
    .o_cmos_data, .o_cmos_data_oe_n, .o_ddr_pair_oe_n,
    .o_forwarded_clock_oe_n, .o_forwarded_clock_pos_oe_n,
    .o_drive_cfg, .o_power_ctl, .o_data_valid
);

// [sample_capture_model.sv]
// Purpose: Receiving logic that captures samples with the forwarded clock.
// Assumes: Samples are held for several clocks by the bench.
// Notes:   Pair 6 carries only padding, so its bits are dropped.
`timescale 1ns/10ps
module sample_capture_model (
    input  wire logic        i_fwd_clk,
    input  wire logic [11:0] i_par_data,
    input  wire logic        i_ddr_clk,
    input  wire logic [6:0]  i_ddr_pair,
    output logic      [11:0] o_par_word,
    output logic      [11:0] o_ddr_word
);
    logic [6:0] even_q;

    always_ff @(posedge i_fwd_clk) begin
        o_par_word <= i_par_data;
    end
    // A quarter period late, each phase of the pairs has settled
    wire #16 ddr_dly = i_ddr_clk;
    always_ff @(posedge ddr_dly) begin
        even_q <= i_ddr_pair;
    end
    always_ff @(negedge ddr_dly) begin
        for (int k = 0; k < 6; k++) begin
            o_ddr_word[2*k]   <= even_q[k];
            o_ddr_word[2*k+1] <= i_ddr_pair[k];
        end
    end
endmodule : sample_capture_model

// [adc_output_and_powerdown_ctrl_tb.sv]
// Purpose: Self-checking bench for the output and power-mode block.
// Assumes: Sampling clock of 64 ns, unrelated in phase to the system clock.
// Notes:   Samples are held for 8 clocks so capture edges never race.
`timescale 1ns/10ps
module adc_output_and_powerdown_ctrl_tb;
    localparam int LIMIT    = 20000;
    localparam int SLOW_LIM = adc_outctl_pkg::WAKE_SLOW_CYC + 8;
    localparam int CMOS_LIM = adc_outctl_pkg::WAKE_CMOS_CYC + 8;
    localparam int LVDS_LIM = adc_outctl_pkg::WAKE_LVDS_CYC + 8;
    logic        clk_sys   = 1'b0;
    logic        clk_samp  = 1'b0;
    logic        samp_run  = 1'b1;
    logic        rstn      = 1'b0;
    logic [3:0]  addr      = 4'h0;
    logic [31:0] wdata     = 32'h0;
    logic        wr_s      = 1'b0;
    logic        rd_s      = 1'b0;
    logic        pdn_pin   = 1'b0;
    logic        data_pin  = 1'b0;
    logic        strap_pin = 1'b0;
    logic [11:0] sample    = 12'h000;
    logic [31:0] rdata, d, v;
    logic [11:0] cmos_data, cmos_oe_n, par_word, ddr_word;
    logic        fclk, fclk_oe_n, fclk_pos, fclk_pos_oe_n, data_valid;
    logic [6:0]  ddr_pair, ddr_oe_n;
    adc_outctl_pkg::drive_cfg_s drive_cfg;
    adc_outctl_pkg::power_ctl_s power_ctl;
    logic [11:0] words [4] = '{12'hA5C, 12'h5A3, 12'hFFF, 12'h001};
    int          err_total = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    always #50 clk_sys = ~clk_sys;
    initial begin
        #7;
        forever #32 if (samp_run) clk_samp = ~clk_samp;
    end

    adc_output_and_powerdown_ctrl uut (
        .i_clk_sys(clk_sys), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_pdn_pin(pdn_pin),
        .i_serial_data_pin(data_pin), .i_interface_strap_pin(strap_pin),
        .i_clk_samp(clk_samp), .i_sample(sample), .o_cmos_data(cmos_data),
        .o_cmos_data_oe_n(cmos_oe_n), .o_forwarded_clock(fclk),
        .o_forwarded_clock_oe_n(fclk_oe_n), .o_ddr_pair(ddr_pair),
        .o_ddr_pair_oe_n(ddr_oe_n), .o_forwarded_clock_pos(fclk_pos),
        .o_forwarded_clock_pos_oe_n(fclk_pos_oe_n), .o_drive_cfg(drive_cfg),
        .o_power_ctl(power_ctl), .o_data_valid(data_valid));
    sample_capture_model rx (
        .i_fwd_clk(fclk), .i_par_data(cmos_data), .i_ddr_clk(fclk_pos),
        .i_ddr_pair(ddr_pair), .o_par_word(par_word), .o_ddr_word(ddr_word));
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] x);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= x;
        wr_s  <= 1'b1;
        @(posedge clk_sys);
        wr_s  <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_sys);
        rd_s <= 1'b0;
        @(negedge clk_sys);
        d = rdata;
    endtask : rd

    task automatic set_mode(input int s, input logic [1:0] m);
        if (s == 0) begin
            @(posedge clk_sys);
            pdn_pin  <= m[0];
            data_pin <= m[1];
        end else
            wr(adc_outctl_pkg::OFS_POWER, {29'h0, 1'b1, m});
    endtask : set_mode

    // Bounded wait: a late wake counts as a mismatch, never a hang
    task automatic wait_valid(input int lim);
        int n;
        n = 0;
        while (data_valid !== 1'b1 && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
        chk("valid", 32'h1, {31'h0, data_valid});
    endtask : wait_valid

    task automatic put_word(input logic [11:0] w);
        @(posedge clk_samp);
        sample <= w;
        repeat (8) @(posedge clk_samp);
    endtask : put_word

    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_total++;
            conclude();
        end
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(adc_outctl_pkg::OFS_OUTPUT);
        chk("output reg", 32'h0, d);
        chk("drive cfg", 32'h0, {21'h0, drive_cfg});
        wr(4'hC, 32'hFFFF_FFFF);
        rd(4'hC);
        chk("unmapped", 32'h0, d);
        wait_valid(SLOW_LIM + 20);
        $display("test reset done");
        for (int s = 0; s < 2; s++) begin
            for (int m = 1; m < 4; m++) begin
                set_mode(s, m[1:0]);
                repeat (20) @(posedge clk_sys);
                rd(adc_outctl_pkg::OFS_STATUS);
                chk("mode", m, {30'h0, d[3:2]});
                chk("core off", m != 2, power_ctl.core_pd);
                chk("ref off", m == 3, power_ctl.ref_pd);
                chk("buf off", m > 1, power_ctl.buf_pd);
                if (m > 1)
                    chk("par float", 32'hFFF, cmos_oe_n);
                set_mode(s, 2'h0);
                wait_valid(m == 2 ? CMOS_LIM : SLOW_LIM);
            end
        end
        wr(adc_outctl_pkg::OFS_POWER, 32'h0);
        $display("test power modes done");
        foreach (words[i]) begin
            put_word(words[i]);
            chk("par word", words[i], par_word);
        end
        chk("par driven", 32'h0, {fclk_oe_n, cmos_oe_n});
        @(posedge clk_sys);
        strap_pin <= 1'b1;
        repeat (20) @(posedge clk_sys);
        wait_valid(SLOW_LIM);
        rd(adc_outctl_pkg::OFS_STATUS);
        chk("ddr by strap", 32'h1, d[6]);
        foreach (words[i]) begin
            put_word(words[i]);
            chk("ddr word", words[i], ddr_word);
        end
        chk("ddr driven", 32'h0, {fclk_pos_oe_n, ddr_oe_n});
        chk("par off", 32'hFFF, cmos_oe_n);
        set_mode(0, 2'h2);
        repeat (20) @(posedge clk_sys);
        chk("ddr float", 32'h7F, ddr_oe_n);
        set_mode(0, 2'h0);
        wait_valid(LVDS_LIM);
        @(posedge clk_sys);
        strap_pin <= 1'b0;
        for (int b = 1; b >= 0; b--) begin
            wr(adc_outctl_pkg::OFS_OUTPUT, 32'h2 | b);
            repeat (20) @(posedge clk_sys);
            rd(adc_outctl_pkg::OFS_STATUS);
            chk("ddr by reg", b, d[6]);
        end
        wait_valid(SLOW_LIM);
        $display("test output bus done");
        for (int c = 0; c < 4; c++) begin
            v = {19'h0, 3'h5, 3'h6, c[0], c[1:0], ~c[0], c[1], 2'h2};
            wr(adc_outctl_pkg::OFS_OUTPUT, v);
            repeat (2) @(posedge clk_sys);
            chk("drive cfg", {21'h0, v[2], v[3], v[5:4], v[6], v[9:7],
                v[12:10]}, drive_cfg);
            rd(adc_outctl_pkg::OFS_OUTPUT);
            chk("output reg", v, d);
        end
        $display("test drive settings done");
        @(posedge clk_sys);
        samp_run <= 1'b0;
        repeat (30) @(posedge clk_sys);
        rd(adc_outctl_pkg::OFS_STATUS);
        chk("clock stop", 32'h1, d[5]);
        chk("stop invalid", 32'h0, data_valid);
        @(posedge clk_sys);
        samp_run <= 1'b1;
        wait_valid(SLOW_LIM + 20);
        $display("test clock stop done");
        conclude();
    end
endmodule : adc_output_and_powerdown_ctrl_tb
